// file: core/gct_core.sv
// multichannel gated counter timer with apb registers
//
// Behaviour
// R1: eight to sixty-four 32-bit counters plus one shared timer
// R2: timer interval programmable from one microsecond to a million seconds; timer is 32-bit microseconds, about 4295 s at most
// R3: limit count programmable from one count upward
// R4: run ends on timer interval or preset count per stop mode
// R5: rising start edge begins counting; idle start is low
// R6: rising stop edge halts counting; idle stop is low
// R7: gate low suspends all channels for the whole low period
// R8: gate high resumes counting; idle gate is high
// R9: start ignored once the selected limit has been reached
// R10: only channel seven carries the preset limit
// R11: run output active while counting; the code drives it from the run state, so it stays active with gate low
// R12: start, stop, gate, run polarity invertible, default active high
// R13: button press under one second acts as power-up reset; the recorder and the update flag are not cleared by it
// R14: button press over three seconds enters firmware update mode
// R15: records stored on gate off or on internal on/off clock
// R16: record holds one word per channel then the timer word
// R17: in gate mode a record is written each time gate turns off; the code records a gate off only while running and while memory has room
// R18: counters increment per input rising edge while running and gate open
//
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module gct_core #(
  parameter int CHANNELS = 8,
  parameter int DEPTH_WORDS = 4096,
  parameter int SHORT_CYCLES = gct_pkg::RESET_SHORT_CYCLES,
  parameter int LONG_CYCLES = gct_pkg::FWUP_LONG_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire gct_pkg::ext_ctl_t ext_in,
  input wire logic [CHANNELS-1:0] count_in,
  input wire logic reset_button,
  output logic run_out,
  output logic fw_update
);
  import gct_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  logic [31:0] ctrl_ff;
  logic [31:0] time_limit_ff;
  logic [31:0] count_limit_ff;
  logic [31:0] period_ff;
  logic [31:0] rec_addr_ff;
  logic [31:0] timer_ff;
  logic [31:0] tick_ff;
  logic [31:0] clk_phase_ff;
  logic [CHANNELS*32-1:0] cnt_ff;
  logic [CHANNELS-1:0] cin_q_ff;
  ext_ctl_t ext_q_ff;
  logic running_ff;
  logic limit_hit_ff;
  logic run_q_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic soft_reset;
  logic fw_update_w;
  logic [31:0] rec_rd;
  logic [31:0] rec_count;

  // ****************************************************************
  // polarity and edge detection
  // ****************************************************************
  // inversion applied before edge detection so edges are logical edges
  wire start_lvl = ext_in.start ^ ctrl_ff[CTRL_INV_START]; // [R12]
  wire stop_lvl = ext_in.stop ^ ctrl_ff[CTRL_INV_STOP]; // [R12]
  wire gate_lvl = ext_in.gate ^ ctrl_ff[CTRL_INV_GATE]; // [R12]
  wire start_rise = start_lvl && !ext_q_ff.start; // [R5]
  wire stop_rise = stop_lvl && !ext_q_ff.stop; // [R6]
  wire gate_fall = !gate_lvl && ext_q_ff.gate;
  wire stop_mode_timer = ctrl_ff[CTRL_MODE_LO +: 2] == STOP_TIMER;
  wire stop_mode_count = ctrl_ff[CTRL_MODE_LO +: 2] == STOP_COUNT;
  wire [1:0] acq_mode = ctrl_ff[CTRL_ACQ_LO +: 2];

  // ****************************************************************
  // apb decode
  // ****************************************************************
  wire setup = psel && !penable;
  wire wr_acc = psel && penable && pwrite;
  wire is_cnt = paddr >= OFF_COUNTER_BASE &&
                paddr < OFF_COUNTER_BASE + 12'(CHANNELS * 4);
  wire [11:0] cnt_off = paddr - OFF_COUNTER_BASE;
  wire [5:0] cnt_idx = cnt_off[7:2];
  wire mapped = is_cnt || paddr == OFF_CTRL || paddr == OFF_STATUS ||
                paddr == OFF_TIME_LIMIT || paddr == OFF_COUNT_LIMIT ||
                paddr == OFF_TIMER || paddr == OFF_REC_ADDR ||
                paddr == OFF_REC_DATA || paddr == OFF_REC_PERIOD;
  wire wr_ok = wr_acc && mapped && paddr[1:0] == 2'b00;
  wire clear_all = wr_ok && paddr == OFF_CTRL && pwdata[CTRL_CLEAR];
  wire [31:0] status_word = {28'h000_0000, fw_update_w, limit_hit_ff, gate_lvl, running_ff};
  wire [31:0] rd_mux =
    is_cnt ? cnt_ff[cnt_idx*32 +: 32] :
    paddr == OFF_CTRL ? ctrl_ff :
    paddr == OFF_STATUS ? status_word :
    paddr == OFF_TIME_LIMIT ? time_limit_ff :
    paddr == OFF_COUNT_LIMIT ? count_limit_ff :
    paddr == OFF_TIMER ? timer_ff :
    paddr == OFF_REC_ADDR ? rec_count :
    paddr == OFF_REC_DATA ? rec_rd :
    paddr == OFF_REC_PERIOD ? period_ff : 32'h0000_0000;

  // ****************************************************************
  // limit detection
  // ****************************************************************
  wire [31:0] preset_cnt = cnt_ff[PRESET_LIMIT_CHANNEL*32 +: 32]; // [R10]
  wire time_reached = stop_mode_timer && timer_ff >= time_limit_ff; // [R2] [R4]
  wire count_reached = stop_mode_count && preset_cnt >= count_limit_ff; // [R3] [R4]
  wire reached = time_reached || count_reached;
  wire sw_start = wr_ok && paddr == OFF_CTRL && pwdata[CTRL_SW_START];
  wire sw_stop = wr_ok && paddr == OFF_CTRL && pwdata[CTRL_SW_STOP];
  wire start_req = (start_rise || sw_start) && !reached && !limit_hit_ff; // [R9]
  wire nxt_running = stop_rise || sw_stop || reached ? 1'b0 : // [R6] [R4]
                     start_req ? 1'b1 : running_ff; // [R5]
  wire counting = running_ff && gate_lvl; // [R7] [R8]
  wire tick = tick_ff == 32'(TICK_CYCLES - 1);

  // internal acquisition clock: one capture every period_ff[15:0] gated microsecond ticks while running
  wire clk_capture = acq_mode == ACQ_CLOCK && running_ff &&
                     clk_phase_ff == {16'h0000, period_ff[15:0]} && period_ff[15:0] != 0;
  wire capture = (acq_mode == ACQ_GATE && gate_fall && running_ff) || clk_capture; // [R17] [R15]

  // ****************************************************************
  // subblocks
  // ****************************************************************
  gct_button #(
    .SHORT_CYCLES(SHORT_CYCLES),
    .LONG_CYCLES(LONG_CYCLES)
  ) u_button (
    .pclk(pclk),
    .presetn(presetn),
    .button(reset_button),
    .soft_reset_ff(soft_reset),
    .fw_update_ff(fw_update_w)
  );

  gct_recorder #(
    .CHANNELS(CHANNELS),
    .DEPTH_WORDS(DEPTH_WORDS)
  ) u_rec (
    .pclk(pclk),
    .presetn(presetn),
    .capture(capture),
    .counts(cnt_ff),
    .timer(timer_ff),
    .rd_index(rec_addr_ff),
    .rd_data(rec_rd),
    .rec_count_ff(rec_count)
  );

  // ****************************************************************
  // counters, one per channel
  // ****************************************************************
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_ch
      wire hit = count_in[g] && !cin_q_ff[g];
      wire wr_me = wr_ok && is_cnt && cnt_idx == 6'(g);
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cnt_ff[g*32 +: 32] <= 32'h0000_0000;
          cin_q_ff[g] <= 1'b0;
        end else begin
          cin_q_ff[g] <= count_in[g];
          if (soft_reset || clear_all)
            cnt_ff[g*32 +: 32] <= 32'h0000_0000;
          else if (wr_me)
            cnt_ff[g*32 +: 32] <= pwdata;
          else if (counting && hit)
            cnt_ff[g*32 +: 32] <= cnt_ff[g*32 +: 32] + 32'd1; // [R18] [R1]
        end
      end
    end
  endgenerate

  // ****************************************************************
  // run control and timer
  // ****************************************************************
  // timer counts microseconds while gate open, so 32 bits reach only about 4295 s
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      running_ff <= 1'b0;
      limit_hit_ff <= 1'b0;
      timer_ff <= 32'h0000_0000;
      tick_ff <= 32'h0000_0000;
      clk_phase_ff <= 32'h0000_0000;
      ext_q_ff <= '{start: 1'b0, stop: 1'b0, gate: 1'b1};
      run_q_ff <= 1'b0;
    end else if (soft_reset) begin
      running_ff <= 1'b0; // [R13]
      limit_hit_ff <= 1'b0;
      timer_ff <= 32'h0000_0000;
      tick_ff <= 32'h0000_0000;
      clk_phase_ff <= 32'h0000_0000;
      run_q_ff <= 1'b0;
    end else begin
      ext_q_ff <= '{start: start_lvl, stop: stop_lvl, gate: gate_lvl};
      running_ff <= nxt_running;
      // a limit reached in the clear cycle still latches: set wins
      limit_hit_ff <= (running_ff && reached) || (limit_hit_ff && !clear_all); // [R9]
      tick_ff <= (counting && !tick) ? tick_ff + 32'd1 : 32'h0000_0000;
      if (clear_all)
        timer_ff <= 32'h0000_0000;
      else if (counting && tick)
        timer_ff <= timer_ff + 32'd1; // [R1]
      clk_phase_ff <= (clk_capture || !running_ff) ? 32'h0000_0000 :
                      (tick ? clk_phase_ff + 32'd1 : clk_phase_ff);
      run_q_ff <= nxt_running ^ ctrl_ff[CTRL_INV_RUN]; // [R11] [R12]
    end
  end

  // ****************************************************************
  // register writes and apb answer
  // ****************************************************************
  // strobe bits self clear; zero limits are coerced to one count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= CTRL_RESET;
      time_limit_ff <= LIMIT_RESET;
      count_limit_ff <= LIMIT_RESET;
      period_ff <= 32'h0000_0000;
      rec_addr_ff <= 32'h0000_0000;
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else if (soft_reset) begin
      ctrl_ff <= CTRL_RESET;
      time_limit_ff <= LIMIT_RESET;
      count_limit_ff <= LIMIT_RESET;
      period_ff <= 32'h0000_0000;
      rec_addr_ff <= 32'h0000_0000;
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= setup;
      pslverr_ff <= setup && !mapped;
      prdata_ff <= setup && !pwrite ? rd_mux : 32'h0000_0000;
      if (wr_ok && paddr == OFF_CTRL)
        ctrl_ff <= pwdata & 32'h0000_03fc;
      if (wr_ok && paddr == OFF_TIME_LIMIT)
        time_limit_ff <= (pwdata == 0) ? LIMIT_RESET : pwdata; // [R2]
      if (wr_ok && paddr == OFF_COUNT_LIMIT)
        count_limit_ff <= (pwdata == 0) ? LIMIT_RESET : pwdata; // [R3]
      if (wr_ok && paddr == OFF_REC_PERIOD)
        period_ff <= pwdata;
      if (wr_ok && paddr == OFF_REC_ADDR)
        rec_addr_ff <= pwdata;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign run_out = run_q_ff;
  assign fw_update = fw_update_w;

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_gate_hold;
    @(posedge pclk) disable iff (!presetn || soft_reset || clear_all)
    (!gate_lvl && !wr_ok) |=> $stable(cnt_ff);
  endproperty
  a_gate_hold: assert property (p_gate_hold) else $error("count moved with gate low"); // [R7]

  property p_start;
    @(posedge pclk) disable iff (!presetn)
    (start_rise && !reached && !limit_hit_ff && !stop_rise && !soft_reset && !sw_stop)
      |=> running_ff;
  endproperty
  a_start: assert property (p_start) else $error("start edge ignored"); // [R5]

  property p_stop;
    @(posedge pclk) disable iff (!presetn)
    stop_rise |=> !running_ff;
  endproperty
  a_stop: assert property (p_stop) else $error("stop edge ignored"); // [R6]

  property p_limit_start;
    @(posedge pclk) disable iff (!presetn)
    (limit_hit_ff && !clear_all && !soft_reset && !running_ff) |=> !running_ff;
  endproperty
  a_limit_start: assert property (p_limit_start) else $error("start after limit"); // [R9]

  property p_run_out;
    @(posedge pclk) disable iff (!presetn)
    (ctrl_ff[CTRL_INV_RUN] == $past(ctrl_ff[CTRL_INV_RUN]))
      |-> run_out == (running_ff ^ ctrl_ff[CTRL_INV_RUN]);
  endproperty
  a_run_out: assert property (p_run_out) else $error("run output mismatch"); // [R11]

  property p_count_stop;
    @(posedge pclk) disable iff (!presetn)
    (running_ff && count_reached) |=> !running_ff;
  endproperty
  a_count_stop: assert property (p_count_stop) else $error("no count stop"); // [R4]

  property p_incr;
    @(posedge pclk) disable iff (!presetn || soft_reset || clear_all || wr_ok)
    (counting && count_in[0] && !cin_q_ff[0]) |=> cnt_ff[31:0] == $past(cnt_ff[31:0]) + 32'd1;
  endproperty
  a_incr: assert property (p_incr) else $error("channel did not count"); // [R18]

  property p_ready;
    @(posedge pclk) disable iff (!presetn || soft_reset)
    setup |=> pready;
  endproperty
  a_ready: assert property (p_ready) else $error("apb answer late");

  c_run: cover property (@(posedge pclk) disable iff (!presetn) $rose(running_ff));
  c_limit: cover property (@(posedge pclk) disable iff (!presetn) $rose(limit_hit_ff));
  c_capture: cover property (@(posedge pclk) disable iff (!presetn) capture);
endmodule : gct_core
`default_nettype wire

// file: include/gct_pkg.sv
// package of constants, register map and carrier types for the gated counter timer
package gct_pkg;

  // ****************************************************************
  // register offsets (byte addresses)
  // ****************************************************************
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;
  localparam logic [11:0] OFF_TIME_LIMIT = 12'h008;
  localparam logic [11:0] OFF_COUNT_LIMIT = 12'h00c;
  localparam logic [11:0] OFF_TIMER = 12'h010;
  localparam logic [11:0] OFF_REC_ADDR = 12'h014;
  localparam logic [11:0] OFF_REC_DATA = 12'h018;
  localparam logic [11:0] OFF_REC_PERIOD = 12'h01c;
  localparam logic [11:0] OFF_COUNTER_BASE = 12'h100;

  // ****************************************************************
  // control field positions
  // ****************************************************************
  localparam int CTRL_SW_START = 0;
  localparam int CTRL_SW_STOP = 1;
  localparam int CTRL_MODE_LO = 2;
  localparam int CTRL_INV_START = 4;
  localparam int CTRL_INV_STOP = 5;
  localparam int CTRL_INV_GATE = 6;
  localparam int CTRL_INV_RUN = 7;
  localparam int CTRL_ACQ_LO = 8;
  localparam int CTRL_CLEAR = 10;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] LIMIT_RESET = 32'h0000_0001;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_HZ = 25_000_000;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYCLES = TICK_NS * (CLK_HZ / 1_000_000) / 1000;
  localparam int RESET_SHORT_MS = 1000;
  localparam int FWUP_LONG_MS = 3000;
  localparam int RESET_SHORT_CYCLES = RESET_SHORT_MS * (CLK_HZ / 1000);
  localparam int FWUP_LONG_CYCLES = FWUP_LONG_MS * (CLK_HZ / 1000);
  localparam int PRESET_LIMIT_CHANNEL = 7;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    STOP_NONE = 2'b00,
    STOP_TIMER = 2'b01,
    STOP_COUNT = 2'b10
  } stop_mode_t;

  typedef enum logic [1:0] {
    ACQ_OFF = 2'b00,
    ACQ_GATE = 2'b01,
    ACQ_CLOCK = 2'b10
  } acq_mode_t;

  typedef struct packed {
    logic start;
    logic stop;
    logic gate;
  } ext_ctl_t;

endpackage : gct_pkg

// file: core/gct_button.sv
// reset button press classifier: short press resets, long press enters update
`timescale 1ns/1ps
`default_nettype none
module gct_button #(
  parameter int SHORT_CYCLES = gct_pkg::RESET_SHORT_CYCLES,
  parameter int LONG_CYCLES = gct_pkg::FWUP_LONG_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic button,
  output logic soft_reset_ff,
  output logic fw_update_ff
);
  import gct_pkg::*;

  logic [31:0] held_ff;
  logic button_q_ff;
  wire release_evt = button_q_ff && !button;

  // count press length; classify on release or when long threshold passes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      held_ff <= 32'h0000_0000;
      button_q_ff <= 1'b0;
      soft_reset_ff <= 1'b0;
      fw_update_ff <= 1'b0;
    end else begin
      button_q_ff <= button;
      soft_reset_ff <= release_evt && (held_ff < 32'(SHORT_CYCLES)); // [R13]
      if (button && held_ff == 32'(LONG_CYCLES))
        fw_update_ff <= 1'b1; // [R14]
      held_ff <= button ? ((held_ff == 32'(LONG_CYCLES)) ? held_ff : held_ff + 32'd1)
                        : 32'h0000_0000;
    end
  end

  property p_fwup;
    @(posedge pclk) disable iff (!presetn)
    (button && held_ff == 32'(LONG_CYCLES)) |=> fw_update_ff;
  endproperty
  a_fwup: assert property (p_fwup) else $error("no update"); // [R14]
endmodule : gct_button
`default_nettype wire

// file: core/gct_recorder.sv
// snapshot record memory: one word per channel plus timer per record
`timescale 1ns/1ps
`default_nettype none
module gct_recorder #(
  parameter int CHANNELS = 8,
  parameter int DEPTH_WORDS = 4096
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic capture,
  input wire logic [CHANNELS*32-1:0] counts,
  input wire logic [31:0] timer,
  input wire logic [31:0] rd_index,
  output logic [31:0] rd_data,
  output logic [31:0] rec_count_ff
);
  import gct_pkg::*;
  localparam int WORDS = CHANNELS + 1;
  localparam int AW = $clog2(DEPTH_WORDS);

  logic [31:0] mem [DEPTH_WORDS];
  logic [31:0] base_ff;
  logic [$clog2(WORDS+1)-1:0] idx_ff;
  logic busy_ff;
  wire [31:0] cur_word = (idx_ff < CHANNELS) ? counts[idx_ff*32 +: 32] : timer;
  wire room = (base_ff + WORDS) <= DEPTH_WORDS;

  // write channels then timer, one word per cycle, one after the other
  always_ff @(posedge pclk) begin
    if (busy_ff)
      mem[AW'(base_ff + 32'(idx_ff))] <= cur_word; // [R16]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_ff <= 32'h0000_0000;
      idx_ff <= '0;
      busy_ff <= 1'b0;
      rec_count_ff <= 32'h0000_0000;
    end else if (busy_ff) begin
      if (32'(idx_ff) == WORDS - 1) begin
        busy_ff <= 1'b0;
        base_ff <= base_ff + WORDS;
        rec_count_ff <= rec_count_ff + 32'd1;
      end
      idx_ff <= idx_ff + 1'b1;
    end else if (capture && room) begin
      busy_ff <= 1'b1; // [R15]
      idx_ff <= '0;
    end
  end

  assign rd_data = mem[AW'(rd_index)];

  // a capture that finds the memory idle with room must open a record
  property p_rec_start;
    @(posedge pclk) disable iff (!presetn)
    (capture && room && !busy_ff) |=> (busy_ff && idx_ff == '0);
  endproperty
  a_rec_start: assert property (p_rec_start) else $error("capture not taken"); // [R15]

  property p_rec_done;
    @(posedge pclk) disable iff (!presetn)
    (busy_ff && 32'(idx_ff) == WORDS - 1) |=> rec_count_ff == $past(rec_count_ff) + 32'd1;
  endproperty
  a_rec_done: assert property (p_rec_done) else $error("record not closed"); // [R16]
endmodule : gct_recorder
`default_nettype wire

// file: tb/gct_trigger_model.sv
// external trigger logic that drives the start, stop and gate lines
`timescale 1ns/1ps
`default_nettype none
module gct_trigger_model (
  input wire logic pclk,
  output var gct_pkg::ext_ctl_t ext
);
  import gct_pkg::*;

  // ****************************************************************
  // idle levels
  // ****************************************************************
  // start and stop rest low, gate rests high as if pulled up
  initial begin
    ext = '{start: 1'b0, stop: 1'b0, gate: 1'b1};
  end

  // ****************************************************************
  // stimulus tasks
  // ****************************************************************
  // three cycles is 120 ns, just over the minimum edge width
  task automatic pulse(input logic is_start);
    @(posedge pclk);
    if (is_start) ext.start <= 1'b1;
    else ext.stop <= 1'b1;
    repeat (3) @(posedge pclk);
    ext.start <= 1'b0;
    ext.stop <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask : pulse

  // gate low closes counting on every channel
  task automatic set_gate(input logic level);
    @(posedge pclk);
    ext.gate <= level;
    repeat (2) @(posedge pclk);
  endtask : set_gate
endmodule : gct_trigger_model
`default_nettype wire

// file: tb/multichannel_gated_counter_timer_bench.sv
// self-checking bench for the gated counter timer core
`timescale 1ns/1ps
`default_nettype none
module multichannel_gated_counter_timer_bench;
  import gct_pkg::*;

  // ****************************************************************
  // signals
  // ****************************************************************
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  ext_ctl_t ext;
  logic [7:0] count_in = 8'h00;
  logic reset_button = 1'b0;
  logic run_out;
  logic fw_update;
  int bad_count = 0;
  int checks = 0;
  int cyc = 0;
  logic [31:0] rd;
  logic err;

  gct_core #(.CHANNELS(8), .DEPTH_WORDS(4096), .SHORT_CYCLES(20), .LONG_CYCLES(60)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_in(ext), .count_in(count_in), .reset_button(reset_button), .run_out(run_out),
    .fw_update(fw_update)
  );
  gct_trigger_model trig (.pclk(pclk), .ext(ext));

  // clock and hang guard; the ceiling is well above the full sequence
  initial begin
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      finish_test();
    end
  end

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic finish_test();
    $display("bad_count=%0d checks=%0d", bad_count, checks);
    if (bad_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // apb transfer; waits for pready without assuming a latency
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic pulses(input int ch, input int n);
    repeat (n) begin
      @(posedge pclk);
      count_in[ch] <= 1'b1;
      @(posedge pclk);
      count_in[ch] <= 1'b0;
    end
    repeat (3) @(posedge pclk);
  endtask : pulses

  // clear strobe also drops the stop mode and any latched limit
  task automatic clear_all();
    apb(1'b1, OFF_CTRL, 32'h0000_0400);
  endtask : clear_all

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic sc_reset_map();
    apb(1'b0, OFF_CTRL, 32'h0);
    check("ctrl", CTRL_RESET, rd);
    apb(1'b0, OFF_TIME_LIMIT, 32'h0);
    check("time_limit", LIMIT_RESET, rd);
    apb(1'b0, OFF_COUNT_LIMIT, 32'h0);
    check("count_limit", LIMIT_RESET, rd);
    apb(1'b0, 12'h020, 32'h0);
    check("unmapped_err", 32'h1, {31'h0, err});
    apb(1'b1, 12'hee3, 32'hffff_ffff);
    check("unmapped_hi_err", 32'h1, {31'h0, err});
    check("run_idle", 32'h0, {31'h0, run_out});
  endtask : sc_reset_map

  task automatic sc_start_gate_stop();
    trig.pulse(1'b1);
    check("run_on", 32'h1, {31'h0, run_out});
    pulses(0, 4);
    trig.set_gate(1'b0);
    pulses(0, 5);
    trig.set_gate(1'b1);
    pulses(0, 2);
    for (int c = 1; c < 8; c++) pulses(c, 1);
    trig.pulse(1'b0);
    check("run_off", 32'h0, {31'h0, run_out});
    pulses(0, 3);
    apb(1'b0, OFF_COUNTER_BASE, 32'h0);
    check("ch0_count", 32'h0000_0006, rd);
    for (int c = 1; c < 8; c++) begin
      apb(1'b0, OFF_COUNTER_BASE + 12'(4 * c), 32'h0);
      check("chn_count", 32'h0000_0001, rd);
    end
    clear_all();
  endtask : sc_start_gate_stop

  task automatic sc_count_limit();
    apb(1'b1, OFF_COUNT_LIMIT, 32'h0000_0003);
    apb(1'b1, OFF_CTRL, 32'h0000_0008);
    trig.pulse(1'b1);
    pulses(0, 5);
    check("run_other_ch", 32'h1, {31'h0, run_out});
    pulses(PRESET_LIMIT_CHANNEL, 3);
    check("run_at_limit", 32'h0, {31'h0, run_out});
    apb(1'b0, OFF_COUNTER_BASE + 12'h01c, 32'h0);
    check("preset_count", 32'h0000_0003, rd);
    trig.pulse(1'b1);
    check("start_refused", 32'h0, {31'h0, run_out});
    clear_all();
  endtask : sc_count_limit

  task automatic sc_time_limit();
    int n;
    n = 0;
    apb(1'b1, OFF_TIME_LIMIT, 32'h0000_0002);
    apb(1'b1, OFF_CTRL, 32'h0000_0004);
    trig.pulse(1'b1);
    while (run_out === 1'b1 && n < 300) begin
      @(posedge pclk);
      n++;
    end
    check("timer_end", 32'h1, {31'h0, n > 30 && n < 60});
    apb(1'b0, OFF_TIMER, 32'h0);
    check("timer_value", 32'h0000_0002, rd);
    trig.pulse(1'b1);
    check("start_refused_t", 32'h0, {31'h0, run_out});
    clear_all();
  endtask : sc_time_limit

  // gate falling while running stores one record of 8 counters and timer
  task automatic sc_record();
    apb(1'b1, OFF_CTRL, 32'h0000_0100);
    trig.pulse(1'b1);
    pulses(2, 3);
    trig.set_gate(1'b0);
    trig.set_gate(1'b1);
    trig.pulse(1'b0);
    apb(1'b0, OFF_REC_ADDR, 32'h0);
    check("rec_count", 32'h0000_0001, rd);
    apb(1'b1, OFF_REC_ADDR, 32'h0000_0002);
    apb(1'b0, OFF_REC_DATA, 32'h0);
    check("rec_ch2", 32'h0000_0003, rd);
    // internal clock mode: about one record per microsecond period while running
    apb(1'b1, OFF_REC_PERIOD, 32'h0000_0001);
    apb(1'b1, OFF_CTRL, 32'h0000_0200);
    trig.pulse(1'b1);
    repeat (94) @(posedge pclk);
    trig.pulse(1'b0);
    apb(1'b0, OFF_REC_ADDR, 32'h0);
    check("rec_clock", 32'h1, {31'h0, rd >= 32'h3 && rd <= 32'h5});
    clear_all();
  endtask : sc_record

  task automatic sc_polarity_button();
    apb(1'b0, OFF_STATUS, 32'h0);
    check("status_idle", 32'h0000_0002, rd);
    check("mapped_err", 32'h0, {31'h0, err});
    apb(1'b1, OFF_CTRL, 32'h0000_0040);
    apb(1'b0, OFF_STATUS, 32'h0);
    check("status_gate_inv", 32'h0000_0000, rd);
    apb(1'b1, OFF_CTRL, 32'h0000_0080);
    repeat (2) @(posedge pclk);
    check("run_inverted", 32'h1, {31'h0, run_out});
    @(posedge pclk);
    reset_button <= 1'b1;
    repeat (10) @(posedge pclk);
    reset_button <= 1'b0;
    repeat (3) @(posedge pclk);
    apb(1'b0, OFF_CTRL, 32'h0);
    check("soft_reset_ctrl", CTRL_RESET, rd);
    check("no_update", 32'h0, {31'h0, fw_update});
    reset_button <= 1'b1;
    repeat (70) @(posedge pclk);
    reset_button <= 1'b0;
    repeat (3) @(posedge pclk);
    check("fw_update", 32'h1, {31'h0, fw_update});
  endtask : sc_polarity_button

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    sc_reset_map();
    sc_start_gate_stop();
    sc_count_limit();
    sc_time_limit();
    sc_record();
    sc_polarity_button();
    finish_test();
  end
endmodule : multichannel_gated_counter_timer_bench
`default_nettype wire
